// >>> src/eel_pkg.sv
/*
  constants for the channel ecc error logger: log layout, offset, reset value.
  assumes a single controller clock and a read-only 64-bit log view.
*/
package eel_pkg;
  localparam logic [11:0] LOG_OFFSET     = 12'h280;
  localparam logic [63:0] LOG_RESET      = 64'h0;
  localparam int          QW_COUNT       = 4;
  localparam int          SYN_W          = 8;
  localparam int          COL_W          = 16;
  localparam int          ROW_W          = 16;
  localparam int          BANK_W         = 3;
  localparam int          RANK_W         = 2;
  localparam int          COL_LSB        = 48;
  localparam int          ROW_LSB        = 32;
  localparam int          BANK_LSB       = 29;
  localparam int          RANK_LSB       = 27;
  localparam int          SYN_LSB        = 16;
  localparam int          UNCORR_BIT     = 1;
  localparam int          CORR_BIT       = 0;

  typedef enum logic [1:0] {
    EEL_NONE   = 2'b00,
    EEL_CORR   = 2'b01,
    EEL_UNCORR = 2'b10
  } eel_kind_t;
endpackage : eel_pkg

// >>> src/eel_prio_sel.sv
/*
  picks the syndrome of one transfer by quadword priority.
  assumes per-quadword error strobes and syndromes valid in the same cycle.
*/
`timescale 1ns/100ps
module eel_prio_sel (
  input  wire logic [eel_pkg::QW_COUNT-1:0]               uncorr_i,
  input  wire logic [eel_pkg::QW_COUNT-1:0]               corr_i,
  input  wire logic [eel_pkg::QW_COUNT*eel_pkg::SYN_W-1:0] syn_i,
  output eel_pkg::eel_kind_t                             kind_o,
  output logic      [eel_pkg::SYN_W-1:0]                 syn_o
);
  // -----------------------------------------------------------------
  // priority pick
  // -----------------------------------------------------------------
  // [RL5] uncorrectable first
  always_comb begin
    kind_o = eel_pkg::EEL_NONE;
    syn_o  = '0;
    for (int i = eel_pkg::QW_COUNT-1; i >= 0; i--) begin
      if (corr_i[i]) begin
        kind_o = eel_pkg::EEL_CORR;
        syn_o  = syn_i[i*eel_pkg::SYN_W +: eel_pkg::SYN_W];
      end
    end
    for (int i = eel_pkg::QW_COUNT-1; i >= 0; i--) begin
      if (uncorr_i[i]) begin
        kind_o = eel_pkg::EEL_UNCORR;
        syn_o  = syn_i[i*eel_pkg::SYN_W +: eel_pkg::SYN_W];
      end
    end
  end
endmodule : eel_prio_sel

// >>> src/eel_logger.sv
/*
  channel ecc error log: captures the first error after software clears the
  central flags, with multi-bit errors overriding single-bit data.
  assumes the ecc checker reports one transfer per cycle with its address,
  and that central status logic pulses a clear per flag.
*/
// How it works
// [RL1] capture only while the channel runs with ecc enabled
// [RL2] after clear, log the first single or multi-bit error address
// [RL3] multi-bit error overwrites logged single-bit address and syndrome
// [RL4] fields frozen while a flag is set, except multi over single
// [RL5] syndrome priority: uncorrectable qw0..3, then correctable qw0..3
// [RL6] column address sits in log bits 63:48
// [RL7] row address sits in log bits 47:32
// [RL8] three-bit bank address sits in log bits 31:29
// [RL9] rank code in bits 28:27, ranks 0-1 module 0, 2-3 module 1
// [RL10] eight-bit syndrome of chosen quadword in bits 23:16
// [RL11] bit 1 set on uncorrectable error, fields logged and locked
// [RL12] bit 0 set on correctable error, fields locked against single errors
// [RL13] flags clear only on central clear indication; log read-only
// [RL14] unused bits read zero, whole log resets to zero
`timescale 1ns/100ps
module eel_logger (
  input  wire logic                                        CLK_I,
  input  wire logic                                        RST_I,
  input  wire logic                                        ECC_EN_I,
  input  wire logic [eel_pkg::QW_COUNT-1:0]                UNCORR_I,
  input  wire logic [eel_pkg::QW_COUNT-1:0]                CORR_I,
  input  wire logic [eel_pkg::QW_COUNT*eel_pkg::SYN_W-1:0] SYN_I,
  input  wire logic [eel_pkg::COL_W-1:0]                   COL_I,
  input  wire logic [eel_pkg::ROW_W-1:0]                   ROW_I,
  input  wire logic [eel_pkg::BANK_W-1:0]                  BANK_I,
  input  wire logic [eel_pkg::RANK_W-1:0]                  RANK_I,
  input  wire logic                                        CLR_UNCORR_I,
  input  wire logic                                        CLR_CORR_I,
  output logic      [63:0]                                 LOG_O
);
  eel_pkg::eel_kind_t          kind;
  logic [eel_pkg::SYN_W-1:0]  pick_syn;
  logic                        uflag_q, uflag_d, cflag_q, cflag_d;
  logic [eel_pkg::COL_W-1:0]  col_q, col_d;
  logic [eel_pkg::ROW_W-1:0]  row_q, row_d;
  logic [eel_pkg::BANK_W-1:0] bank_q, bank_d;
  logic [eel_pkg::RANK_W-1:0] rank_q, rank_d;
  logic [eel_pkg::SYN_W-1:0]  syn_q, syn_d;
  logic                        load;
  logic [63:0]                 log_d;

  eel_prio_sel u_sel (
    .uncorr_i (UNCORR_I),
    .corr_i   (CORR_I),
    .syn_i    (SYN_I),
    .kind_o   (kind),
    .syn_o    (pick_syn)
  );

  // -----------------------------------------------------------------
  // log image
  // -----------------------------------------------------------------
  // [RL14] unused bits read zero
  function automatic logic [63:0] pack_log(
    input logic [eel_pkg::COL_W-1:0]  col,
    input logic [eel_pkg::ROW_W-1:0]  row,
    input logic [eel_pkg::BANK_W-1:0] bank,
    input logic [eel_pkg::RANK_W-1:0] rank,
    input logic [eel_pkg::SYN_W-1:0]  syn,
    input logic                       uflag,
    input logic                       cflag
  );
    logic [63:0] img;
    img = '0;
    // [RL6] column field
    img[eel_pkg::COL_LSB +: eel_pkg::COL_W]   = col;
    // [RL7] row field
    img[eel_pkg::ROW_LSB +: eel_pkg::ROW_W]   = row;
    // [RL8] bank field
    img[eel_pkg::BANK_LSB +: eel_pkg::BANK_W] = bank;
    // [RL9] rank field
    img[eel_pkg::RANK_LSB +: eel_pkg::RANK_W] = rank;
    // [RL10] syndrome field
    img[eel_pkg::SYN_LSB +: eel_pkg::SYN_W]   = syn;
    // [RL11] [RL12] flag bits
    img[eel_pkg::UNCORR_BIT]                  = uflag;
    img[eel_pkg::CORR_BIT]                    = cflag;
    return img;
  endfunction : pack_log

  // -----------------------------------------------------------------
  // capture and flags
  // -----------------------------------------------------------------
  always_comb begin
    uflag_d = uflag_q;
    cflag_d = cflag_q;
    col_d   = col_q;
    row_d   = row_q;
    bank_d  = bank_q;
    rank_d  = rank_q;
    syn_d   = syn_q;
    load    = 1'b0;
    // [RL13] central clear indication
    // the clear acts first so that a set in the same cycle wins
    if (CLR_UNCORR_I) uflag_d = 1'b0;
    if (CLR_CORR_I) cflag_d = 1'b0;
    // [RL1] ecc gating, [RL2] [RL4] lock while flagged
    if (ECC_EN_I) begin
      // [RL11] [RL3] uncorrectable logs unless already locked by one
      if (kind == eel_pkg::EEL_UNCORR) begin
        uflag_d = 1'b1;
        load    = !uflag_q;
      end else if (kind == eel_pkg::EEL_CORR) begin
        // [RL12] single-bit only logs when nothing is locked
        cflag_d = 1'b1;
        load    = !uflag_q && !cflag_q;
      end
    end
    // set wins over a same-cycle clear, but the old flag still blocks the load
    if (load) begin
      col_d  = COL_I;
      row_d  = ROW_I;
      bank_d = BANK_I;
      rank_d = RANK_I;
      syn_d  = pick_syn;
    end
    log_d = pack_log(col_d, row_d, bank_d, rank_d, syn_d, uflag_d, cflag_d);
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      uflag_q <= 1'b0;
      cflag_q <= 1'b0;
      col_q   <= '0;
      row_q   <= '0;
      bank_q  <= '0;
      rank_q  <= '0;
      syn_q   <= '0;
      LOG_O   <= eel_pkg::LOG_RESET;
    end else begin
      uflag_q <= uflag_d;
      cflag_q <= cflag_d;
      col_q   <= col_d;
      row_q   <= row_d;
      bank_q  <= bank_d;
      rank_q  <= rank_d;
      syn_q   <= syn_d;
      LOG_O   <= log_d;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  ecc_gate_a: assert property (!ECC_EN_I && !CLR_UNCORR_I && !CLR_CORR_I |=> // [RL1]
    $stable(LOG_O)) else $error("log changed with ecc off");
  unc_set_a: assert property (ECC_EN_I && |UNCORR_I |=> LOG_O[1]) // [RL11]
    else $error("uncorrectable flag not set");
  cor_set_a: assert property (ECC_EN_I && |CORR_I && ~|UNCORR_I |=> LOG_O[0]) // [RL12]
    else $error("correctable flag not set");
  unc_lock_a: assert property (LOG_O[1] && !CLR_UNCORR_I |=> // [RL4]
    $stable(LOG_O[63:16])) else $error("locked fields moved");
  multi_over_a: assert property (ECC_EN_I && |UNCORR_I && !LOG_O[1] |=> // [RL3]
    LOG_O[63:48] == $past(COL_I) && LOG_O[47:32] == $past(ROW_I))
    else $error("multi-bit did not overwrite");
  first_cor_a: assert property (ECC_EN_I && |CORR_I && ~|UNCORR_I && !LOG_O[1] // [RL2]
    && !LOG_O[0] |=> LOG_O[31:29] == $past(BANK_I) && LOG_O[28:27] == $past(RANK_I))
    else $error("first single error not logged");
  prio_syn_a: assert property (ECC_EN_I && UNCORR_I[0] && !LOG_O[1] |=> // [RL5]
    LOG_O[23:16] == $past(SYN_I[7:0])) else $error("syndrome priority wrong");
  clr_only_a: assert property ($fell(LOG_O[0]) |-> $past(CLR_CORR_I)) // [RL13]
    else $error("flag cleared without indication");
  zero_bits_a: assert property (LOG_O[26:24] == 3'h0 && LOG_O[15:2] == 14'h0) // [RL14]
    else $error("reserved bits nonzero");

  // -----------------------------------------------------------------
  // clears, locks, priority, reset and ecc gating
  // -----------------------------------------------------------------
  unc_clr_a: assert property ($fell(LOG_O[1]) |-> $past(CLR_UNCORR_I)) // [RL13]
    else $error("uncorrectable flag cleared without indication");
  unc_keep_a: assert property (LOG_O[1] && !CLR_UNCORR_I |=> LOG_O[1]) // [RL13]
    else $error("uncorrectable flag lost");
  cor_keep_a: assert property (LOG_O[0] && !CLR_CORR_I |=> LOG_O[0]) // [RL13]
    else $error("correctable flag lost");
  cor_lock_a: assert property (LOG_O[0] && !LOG_O[1] && !(ECC_EN_I && |UNCORR_I) // [RL12]
    |=> $stable(LOG_O[63:16]))
    else $error("single-bit error moved locked fields");
  cor_addr_a: assert property (ECC_EN_I && |CORR_I && ~|UNCORR_I && LOG_O[1:0] == 2'h0 // [RL2]
    |=> LOG_O[63:48] == $past(COL_I) && LOG_O[47:32] == $past(ROW_I))
    else $error("first single error address not logged");
  unc_log_a: assert property (ECC_EN_I && |UNCORR_I && !LOG_O[1] // [RL11]
    |=> LOG_O[31:29] == $past(BANK_I) && LOG_O[28:27] == $past(RANK_I))
    else $error("multi-bit error bank or rank not logged");
  prio_unc1_a: assert property (ECC_EN_I && UNCORR_I[1:0] == 2'h2 && !LOG_O[1] // [RL5]
    |=> LOG_O[23:16] == $past(SYN_I[15:8]))
    else $error("uncorrectable quadword 1 syndrome wrong");
  prio_unc3_a: assert property (ECC_EN_I && UNCORR_I == 4'h8 && !LOG_O[1] // [RL5]
    |=> LOG_O[23:16] == $past(SYN_I[31:24]))
    else $error("uncorrectable quadword 3 syndrome wrong");
  prio_cor_a: assert property (ECC_EN_I && ~|UNCORR_I && CORR_I[0] && LOG_O[1:0] == 2'h0 // [RL5]
    |=> LOG_O[23:16] == $past(SYN_I[7:0]))
    else $error("correctable quadword 0 syndrome wrong");
  prio_cor2_a: assert property (ECC_EN_I && ~|UNCORR_I && CORR_I[2:0] == 3'h4 // [RL5]
    && LOG_O[1:0] == 2'h0 |=> LOG_O[23:16] == $past(SYN_I[23:16]))
    else $error("correctable quadword 2 syndrome wrong");
  same_xfer_a: assert property (ECC_EN_I && |UNCORR_I && !LOG_O[0] |=> !LOG_O[0]) // [RL11]
    else $error("correctable flag set by a multi-bit transfer");
  rst_zero_a: assert property (disable iff (1'h0) RST_I |=> // [RL14]
    LOG_O == eel_pkg::LOG_RESET) else $error("log not cleared by reset");
  ecc_fields_a: assert property (!ECC_EN_I |=> $stable(LOG_O[63:16])) // [RL1]
    else $error("fields moved with ecc off");
  ecc_flag_a: assert property (!ECC_EN_I && !LOG_O[0] |=> !LOG_O[0]) // [RL1]
    else $error("correctable flag set with ecc off");

  // -----------------------------------------------------------------
  // coverage
  // -----------------------------------------------------------------
  unc_hit_c: cover property (ECC_EN_I && |UNCORR_I && LOG_O[0]);
  cor_hit_c: cover property (ECC_EN_I && |CORR_I && !LOG_O[0]);
  clr_c: cover property (CLR_UNCORR_I && LOG_O[1]);
  over_single_c: cover property (ECC_EN_I && |UNCORR_I && LOG_O[1:0] == 2'h1);
  set_clr_c: cover property (ECC_EN_I && |CORR_I && CLR_CORR_I);
endmodule : eel_logger

// >>> test/eel_src_model.sv
/*
  far side model: ecc checker strobes per transfer and central flag clears.
  assumes the bench calls send; drives only on the falling clock edge.
*/
`timescale 1ns/100ps
module eel_src_model (
  input  wire logic        clk_i,
  output logic      [3:0]  uncorr_o,
  output logic      [3:0]  corr_o,
  output logic      [31:0] syn_o,
  output logic      [36:0] addr_o,
  output logic      [1:0]  clr_o
);
  initial begin
    {uncorr_o, corr_o, syn_o, addr_o, clr_o} = '0;
  end
  // ---------------------------------------------------------------
  // one transfer or clear pulse, one cycle wide
  // ---------------------------------------------------------------
  task automatic send(input logic [3:0] u, input logic [3:0] c, input logic [31:0] s,
                      input logic [36:0] a, input logic [1:0] k);
    @(negedge clk_i);
    {uncorr_o, corr_o, syn_o, addr_o, clr_o} = {u, c, s, a, k};
    @(negedge clk_i);
    // stale data is inverted so a late sample cannot pass by luck
    {uncorr_o, corr_o, syn_o, addr_o, clr_o} = {4'h0, 4'h0, ~s, ~a, 2'h0};
  endtask : send
endmodule : eel_src_model

// >>> test/test_ecc_error_logger.sv
/*
  self-checking bench for the ecc error logger.
  assumes eel_pkg and eel_logger are compiled first; far side is eel_src_model.
*/
`timescale 1ns/100ps
module test_ecc_error_logger;
  logic        clk;
  logic        rst;
  logic        ecc_en;
  logic [3:0]  uncorr;
  logic [3:0]  corr;
  logic [31:0] syn;
  logic [36:0] addr;
  logic [1:0]  clr;
  logic [63:0] log_w;
  int          err_count;
  int          n_tests;
  eel_logger eel_logger_inst (.CLK_I(clk), .RST_I(rst), .ECC_EN_I(ecc_en), .UNCORR_I(uncorr),
    .CORR_I(corr), .SYN_I(syn), .COL_I(addr[36:21]), .ROW_I(addr[20:5]), .BANK_I(addr[4:2]),
    .RANK_I(addr[1:0]), .CLR_UNCORR_I(clr[1]), .CLR_CORR_I(clr[0]), .LOG_O(log_w));
  eel_src_model eel_src_model_inst (.clk_i(clk), .uncorr_o(uncorr), .corr_o(corr),
    .syn_o(syn), .addr_o(addr), .clr_o(clr));
  // ---------------------------------------------------------------
  // expected log image: address, zero gap, syndrome, zero gap, flags
  // ---------------------------------------------------------------
  function automatic logic [63:0] img(input logic [1:0] f, input logic [7:0] s,
                                      input logic [36:0] a);
    return {a, 3'h0, s, 14'h0, f};
  endfunction : img
  task automatic chk(input logic [63:0] e);
    n_tests++;
    if (log_w !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t log %h exp %h", $time, log_w, e);
    end
  endtask : chk
  task automatic summarize();
    $display("mismatches %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic scn_disabled();
    ecc_en = 1'b0;
    eel_src_model_inst.send(4'h1, 4'h1, 32'h11223344, 37'h01_2345_6789, 2'h0);
    chk(64'h0);
    ecc_en = 1'b1;
  endtask : scn_disabled
  task automatic scn_corr();
    eel_src_model_inst.send(4'h0, 4'hc, 32'haabbccdd, 37'h0a_5a5a_c3c5, 2'h0);
    chk(img(2'b01, 8'hbb, 37'h0a_5a5a_c3c5));
    eel_src_model_inst.send(4'h0, 4'h1, 32'h000000ee, 37'h00_0f0f_0f00, 2'h0);
    chk(img(2'b01, 8'hbb, 37'h0a_5a5a_c3c5));
  endtask : scn_corr
  task automatic scn_multi();
    eel_src_model_inst.send(4'h8, 4'h1, 32'h55667788, 37'h1c_3c3c_96e7, 2'h0);
    chk(img(2'b11, 8'h55, 37'h1c_3c3c_96e7));
    eel_src_model_inst.send(4'h1, 4'h0, 32'h000000f1, 37'h00_1111_1100, 2'h0);
    chk(img(2'b11, 8'h55, 37'h1c_3c3c_96e7));
  endtask : scn_multi
  task automatic scn_clear();
    eel_src_model_inst.send(4'h0, 4'h0, 32'h0, 37'h0, 2'b10);
    chk(img(2'b01, 8'h55, 37'h1c_3c3c_96e7));
    eel_src_model_inst.send(4'h0, 4'h0, 32'h0, 37'h0, 2'b01);
    chk(img(2'b00, 8'h55, 37'h1c_3c3c_96e7));
    eel_src_model_inst.send(4'h6, 4'h1, 32'h99887766, 37'h06_1234_5676, 2'h0);
    chk(img(2'b10, 8'h77, 37'h06_1234_5676));
  endtask : scn_clear
  task automatic scn_prio();
    eel_src_model_inst.send(4'h0, 4'h0, 32'h0, 37'h0, 2'h3);
    chk(img(2'h0, 8'h77, 37'h06_1234_5676));
    eel_src_model_inst.send(4'h0, 4'h3, 32'h44332211, 37'h15_a5a5_5a5b, 2'h0);
    chk(img(2'h1, 8'h11, 37'h15_a5a5_5a5b));
    eel_src_model_inst.send(4'h0, 4'h4, 32'h00ee0000, 37'h03_0303_0303, 2'h1);
    chk(img(2'h1, 8'h11, 37'h15_a5a5_5a5b));
    eel_src_model_inst.send(4'h9, 4'h6, 32'hd4c3b2a1, 37'h0e_7e7e_1236, 2'h0);
    chk(img(2'h3, 8'ha1, 37'h0e_7e7e_1236));
  endtask : scn_prio
  task automatic scn_reset();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(64'h0);
    eel_src_model_inst.send(4'h0, 4'h2, 32'h00005a00, 37'h1f_0000_ffff, 2'h0);
    chk(img(2'h1, 8'h5a, 37'h1f_0000_ffff));
  endtask : scn_reset
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a hang counts as a mismatch and ends the run
  initial begin
    #400000;
    err_count++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    ecc_en = 1'b1;
    err_count = 0;
    n_tests = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk(64'h0);
    scn_disabled();
    scn_corr();
    scn_multi();
    scn_clear();
    scn_prio();
    scn_reset();
    summarize();
  end
endmodule : test_ecc_error_logger
